// >>> rtl/tic_capture.sv
// input capture unit with wishbone registers and port pin control
//
// Contract
// [RQ1] latch timer on qualified capture edge
// [RQ2] filter rejects pulses shorter than two samples
// [RQ3] sample capture pin every four clocks
// [RQ4] sampling independent of counter source clock
// [RQ5] lock out captures until latest read
// [RQ6] software reads latest low then high
// [RQ7] capture correct across counter wrap
// [RQ8] edge select rising falling or both
// [RQ9] pair enable at bit0 of earlier low
// [RQ10] pair mode interrupts on second edge
// [RQ11] pair keeps first earlier, second latest
// [RQ12] hardware clears pair enable after edge
// [RQ13] reading second time re-enables capture
// [RQ14] software reads earlier before latest
// [RQ15] software sets pair before first edge
// [RQ16] unused pins act as plain port pins
// [RQ17] software makes line6 input for capture
// [RQ18] software sets latch then direction line7
// [RQ19] interrupt pulse with capture register load
// [RQ20] high byte read of latest releases lockout
// [RQ21] edge from two consecutive stable samples
`timescale 1ns/1ns
module tic_capture #(
   parameter int TIMER_WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [TIMER_WIDTH-1:0] extended_timer_i,
   input wire logic timer_uses_capture_i,
   input wire logic timer_uses_compare_i,
   input wire logic compare_level_i,
   input wire logic port3_line6_i,
   output logic port3_line6_o,
   output logic port3_line6_oe_o,
   input wire logic port3_line7_i,
   output logic port3_line7_o,
   output logic port3_line7_oe_o,
   output logic capture_irq_o
);

   // elaboration check on the timer width
   // the byte map covers sixteen bits only
   if (TIMER_WIDTH != 16)
   begin : g_width_check
      $error("tic_capture serves a 16-bit timer only");
   end

   // state of the register bus slave and capture logic
   logic [1:0] div_q, div_d;
   logic s1_q, s1_d, s2_q, s2_d;
   logic [1:0] hist_q, hist_d;
   logic filt_q, filt_d;
   logic [7:0] mode_q, mode_d;
   logic [7:0] dir_q, dir_d;
   logic [7:0] latch_q, latch_d;
   logic [15:0] latest_q, latest_d;
   logic [15:0] earlier_q, earlier_d;
   logic pair_q, pair_d;
   logic lock_q, lock_d;
   logic pair_first_q, pair_first_d;
   logic irq_q, irq_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic l6_q, l6_d, l6oe_q, l6oe_d, l7_q, l7_d, l7oe_q, l7oe_d;
   logic tick;
   logic edge_seen;
   logic bus_req;
   logic rd_high;

   // pick the edge that the mode nibble asks for
   function automatic logic edge_match(input logic [3:0] mode, input logic prev, input logic cur);
      logic rise;
      logic fall;
      rise = !prev && cur;
      fall = prev && !cur;
      case (mode)
         tic_pkg::MODE_RISE: edge_match = rise;
         tic_pkg::MODE_FALL: edge_match = fall;
         tic_pkg::MODE_BOTH: edge_match = rise || fall;
         default: edge_match = 1'b0;
      endcase
   endfunction : edge_match

   // byte lane merge for writes
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [3:0] sel, input logic [31:0] dat);
      lane0 = sel[0] ? dat[7:0] : old;
   endfunction : lane0

   // address compare for the bus decodes that feed the capture logic (lockout release, pair enable)
   function automatic logic adr_is(input logic [4:0] adr, input logic [4:0] want);
      adr_is = (adr == want);
   endfunction : adr_is

   always_comb
   begin
      // [RQ3] divide by four
      tick = (div_q == 2'(tic_pkg::SAMPLE_DIV - 1));
      bus_req = wb_cyc_i && wb_stb_i && !ack_q;
      rd_high = bus_req && !wb_we_i && adr_is(wb_adr_i, 5'(tic_pkg::ADDR_LATEST_HIGH));
      // [RQ21] compare last two raw samples, both differing from the filtered level
      edge_seen = tick && (hist_q[0] == hist_q[1]) && (hist_q[0] != filt_q)
                  && edge_match(mode_q[7:4], filt_q, hist_q[0]);
   end

   // sampler and filter next state
   always_comb
   begin
      // [RQ4] divider runs from main clock only
      // free running, so the counter source choice never reaches it
      div_d = div_q + 2'h1;
      // pin passes two flops before use
      s1_d = port3_line6_i;
      s2_d = s1_q;
      // only the second flop feeds the sample history
      hist_d = hist_q;
      filt_d = filt_q;
      // [RQ2] accept level only when two samples agree
      if (tick)
      begin
         hist_d = {hist_q[0], s2_q};
         if (hist_q[0] == hist_q[1])
         begin
            filt_d = hist_q[0];
         end
      end
   end

   // capture registers, lockout and interrupt next state
   always_comb
   begin
      // a read and an edge in one cycle: edge refused, lock_q still holds
      latest_d = latest_q;
      earlier_d = earlier_q;
      pair_d = pair_q;
      lock_d = lock_q;
      pair_first_d = pair_first_q;
      irq_d = 1'b0;
      // [RQ20] lockout ends on latest high read
      if (rd_high)
      begin
         // [RQ13] read of second time re-arms
         lock_d = 1'b0;
      end
      // [RQ5] edges ignored while locked
      if (edge_seen && !lock_q && timer_uses_capture_i)
      begin
         // [RQ7] raw count copied, wrap is harmless
         if (pair_q && !pair_first_q)
         begin
            // [RQ11] first edge goes to earlier
            earlier_d = extended_timer_i;
            pair_first_d = 1'b1;
            // [RQ12] hardware clears pair enable
            pair_d = 1'b0;
         end
         else
         begin
            // [RQ1] latch timer into latest
            latest_d = extended_timer_i;
            lock_d = 1'b1;
            pair_first_d = 1'b0;
            // [RQ19] interrupt with the load
            // [RQ10] pair interrupts on second edge only
            irq_d = 1'b1;
         end
      end
      // [RQ9] pair enable write, bit0 of earlier low
      // written last, so a software set wins over the hardware clear
      if (bus_req && wb_we_i && adr_is(wb_adr_i, 5'(tic_pkg::ADDR_EARLIER_LOW)) && wb_sel_i[0])
      begin
         pair_d = wb_dat_i[tic_pkg::PAIR_BIT];
      end
   end

   // bus slave and port pin next state
   always_comb
   begin
      mode_d = mode_q;
      dir_d = dir_q;
      latch_d = latch_q;
      ack_d = bus_req;
      rdat_d = 32'h0000_0000;
      if (bus_req && wb_we_i)
      begin
         if (wb_adr_i == tic_pkg::ADDR_MODE)
         begin
            // [RQ8] mode control selects the edge
            mode_d = lane0(mode_q, wb_sel_i, wb_dat_i);
         end
         else if (wb_adr_i == tic_pkg::ADDR_PORT)
         begin
            latch_d = lane0(latch_q, wb_sel_i, wb_dat_i);
            dir_d = wb_sel_i[1] ? wb_dat_i[15:8] : dir_q;
         end
      end
      else if (bus_req)
      begin
         if (wb_adr_i == 5'(tic_pkg::ADDR_LATEST_LOW))
         begin
            rdat_d = {24'h00_0000, latest_q[7:0]};
         end
         else if (wb_adr_i == 5'(tic_pkg::ADDR_LATEST_HIGH))
         begin
            rdat_d = {24'h00_0000, latest_q[15:8]};
         end
         else if (wb_adr_i == 5'(tic_pkg::ADDR_EARLIER_LOW))
         begin
            rdat_d = {24'h00_0000, earlier_q[7:0]};
         end
         else if (wb_adr_i == 5'(tic_pkg::ADDR_EARLIER_HIGH))
         begin
            rdat_d = {24'h00_0000, earlier_q[15:8]};
         end
         else if (wb_adr_i == tic_pkg::ADDR_MODE)
         begin
            rdat_d = {24'h00_0000, mode_q};
         end
         else if (wb_adr_i == tic_pkg::ADDR_PORT)
         begin
            rdat_d = {16'h0000, dir_q, latch_q};
         end
         // unmapped reads return zero but are still acknowledged
         else
         begin
            rdat_d = 32'h0000_0000;
         end
      end
   end

   // port pin next state
   always_comb
   begin
      // [RQ16] pins are plain port lines unless claimed
      // line7 follows the compare level only while the timer claims it
      l6_d = latch_q[tic_pkg::LINE6_BIT];
      l6oe_d = dir_q[tic_pkg::LINE6_BIT];
      l7_d = timer_uses_compare_i ? compare_level_i : latch_q[tic_pkg::LINE7_BIT];
      l7oe_d = dir_q[tic_pkg::LINE7_BIT];
   end

   // sampler and filter registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_q <= 2'h0;
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         hist_q <= 2'h0;
         filt_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         s1_q <= s1_d;
         s2_q <= s2_d;
         hist_q <= hist_d;
         filt_q <= filt_d;
      end
   end

   // capture registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         latest_q <= tic_pkg::CAPTURE_RESET;
         earlier_q <= tic_pkg::CAPTURE_RESET;
         pair_q <= 1'b0;
         lock_q <= 1'b0;
         pair_first_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         latest_q <= latest_d;
         earlier_q <= earlier_d;
         pair_q <= pair_d;
         lock_q <= lock_d;
         pair_first_q <= pair_first_d;
         irq_q <= irq_d;
      end
   end

   // bus slave registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode_q <= tic_pkg::MODE_RESET;
         dir_q <= 8'h00;
         latch_q <= 8'h00;
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         mode_q <= mode_d;
         dir_q <= dir_d;
         latch_q <= latch_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // port pin registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         l6_q <= 1'b0;
         l6oe_q <= 1'b0;
         l7_q <= 1'b0;
         l7oe_q <= 1'b0;
      end
      else
      begin
         l6_q <= l6_d;
         l6oe_q <= l6oe_d;
         l7_q <= l7_d;
         l7oe_q <= l7oe_d;
      end
   end

   // outputs straight from flops; pin inputs unused beyond line6
   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;
   assign capture_irq_o = irq_q;
   assign port3_line6_o = l6_q;
   assign port3_line6_oe_o = l6oe_q;
   assign port3_line7_o = l7_q;
   assign port3_line7_oe_o = l7oe_q;

endmodule : tic_capture

// >>> inc/tic_pkg.sv
// shared constants for the timer input capture block
package tic_pkg;
   // byte register offsets on the wishbone bus
   localparam logic [3:0] ADDR_LATEST_LOW = 4'h0;
   localparam logic [3:0] ADDR_LATEST_HIGH = 4'h4;
   localparam logic [3:0] ADDR_EARLIER_LOW = 4'h8;
   localparam logic [3:0] ADDR_EARLIER_HIGH = 4'hc;
   localparam logic [3:0] ADDR_MODE_CTL = 4'h0 + 4'h0;
   // mode register, own word at 0x10
   localparam logic [4:0] ADDR_MODE = 5'h10;
   localparam logic [4:0] ADDR_PORT = 5'h14;
   // mode control patterns of the upper nibble
   localparam logic [3:0] MODE_RISE = 4'h5;
   localparam logic [3:0] MODE_FALL = 4'h6;
   localparam logic [3:0] MODE_BOTH = 4'h7;
   // field positions
   localparam int PAIR_BIT = 0;
   localparam int LINE6_BIT = 6;
   localparam int LINE7_BIT = 7;
   // reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] CAPTURE_RESET = 16'h0000;
   // sampling divider: main clock over four
   localparam int SAMPLE_DIV = 4;
endpackage : tic_pkg

// >>> verification/tic_pulse_model.sv
// partner model: pulse source driving the capture pin
`timescale 1ns/1ns
module tic_pulse_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [7:0] len_i,
   output logic pin_o
);
   logic [7:0] cnt_q;
   // pin high for len cycles, idles low between pulses
   always_ff @(posedge clk_i)
   begin
      if (rst_i || go_i)
      begin
         pin_o <= go_i;
         cnt_q <= go_i ? len_i : 8'h00;
      end
      else if (cnt_q != 8'h00)
      begin
         cnt_q <= cnt_q - 8'h01;
         pin_o <= cnt_q != 8'h01;
      end
   end
endmodule : tic_pulse_model

// >>> verification/tic_capture_props.sv
// port checker for the input capture block
`timescale 1ns/1ns
module tic_capture_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic timer_uses_compare_i,
   input wire logic compare_level_i,
   input wire logic port3_line7_o,
   input wire logic port3_line6_oe_o,
   input wire logic port3_line7_oe_o,
   input wire logic capture_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic lock_q;
   logic lock_d;
   // lock set by irq, dropped when a latest-high read is taken
   always_comb
      lock_d = capture_irq_o ? 1'b1 : (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
         && wb_adr_i == 5'h04) ? 1'b0 : lock_q;
   always_ff @(posedge clk_i)
      lock_q <= rst_i ? 1'b0 : lock_d;
   a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack stray");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 5'h14 |-> wb_dat_o == 32'h0)
      else $error("unmapped data");
   a_irq_single: assert property (capture_irq_o |=> !capture_irq_o) else $error("irq long");
   a_irq_locked: assert property (lock_q |-> !capture_irq_o) else $error("irq while locked");
   a_line7_follow: assert property ($past(!rst_i && timer_uses_compare_i) |->
      port3_line7_o == $past(compare_level_i)) else $error("line7 level");
   a_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && !capture_irq_o && !port3_line6_oe_o
      && !port3_line7_oe_o) else $error("reset outputs");
endmodule : tic_capture_props
bind tic_capture tic_capture_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .timer_uses_compare_i, .compare_level_i, .port3_line7_o, .port3_line6_oe_o,
   .port3_line7_oe_o, .capture_irq_o);

// >>> verification/testbench.sv
// self-checking bench for the input capture block
`timescale 1ns/1ns
module testbench;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, cap = 1'b0, ucmp = 1'b0, cmp = 1'b0;
   logic go = 1'b0, l7 = 1'b0, jmp = 1'b0, pin, ack, irq, o6, oe6, o7, oe7;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0, rd;
   logic [15:0] tmr = 16'h0, jv = 16'h0;
   logic [7:0] len = 8'h00;
   logic [3:0] modes [3] = '{4'h5, 4'h6, 4'h7};
   int err_total = 0, num_checks = 0;
   always #5 clk_i = ~clk_i;
   // free running count, wraps on purpose
   always @(posedge clk_i) tmr <= jmp ? jv : tmr + 16'h0001;
   tic_capture u_tic_capture (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .extended_timer_i(tmr),
      .timer_uses_capture_i(cap), .timer_uses_compare_i(ucmp), .compare_level_i(cmp),
      .port3_line6_i(oe6 ? o6 : pin), .port3_line6_o(o6), .port3_line6_oe_o(oe6), .port3_line7_i(l7),
      .port3_line7_o(o7), .port3_line7_oe_o(oe7), .capture_irq_o(irq));
   tic_pulse_model u_tic_pulse_model (.clk_i, .rst_i, .go_i(go), .len_i(len), .pin_o(pin));
   task automatic summarize;
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         err_total++;
         summarize();
      end
      q = rd;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic rd16(input logic [4:0] a, output logic [15:0] v);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      v[7:0] = q[7:0];
      wb(1'b0, a + 5'h04, 32'h0, q);
      v[15:8] = q[7:0];
   endtask : rd16
   // waits for pin low plus settle, so every pulse has a fresh rise
   task automatic pulse(input logic [7:0] w, output logic [15:0] t0);
      for (int i = 0; i < 300 && pin !== 1'b0; i++) @(posedge clk_i);
      repeat (12) @(posedge clk_i);
      go <= 1'b1;
      len <= w;
      @(posedge clk_i);
      go <= 1'b0;
      t0 = tmr;
   endtask : pulse
   task automatic wait_irq(input int lim, output logic got);
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++)
      begin
         @(posedge clk_i);
         got = irq === 1'b1;
      end
   endtask : wait_irq
   // edge time to stored count, modulo wrap
   function automatic logic lag_ok(input logic [15:0] v, t0);
      return (v - t0) > 16'd2 && (v - t0) < 16'd20;
   endfunction : lag_ok
   initial
   begin
      logic [31:0] q;
      logic [15:0] t0, t1, v;
      logic [7:0] w;
      logic got;
      q = $urandom(32'h9d0f);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 28; a += 4)
      begin
         wb(1'b0, 5'(a), 32'h0, q);
         chk("reset", q, 32'h0);
      end
      wb(1'b1, tic_pkg::ADDR_PORT, 32'h0080, q);
      wb(1'b1, tic_pkg::ADDR_PORT, 32'hc080, q);
      chk("port", {oe6, oe7, o7, o6}, 4'he);
      cmp <= 1'($urandom);
      ucmp <= 1'b1;
      l7 <= 1'($urandom);
      repeat (2) @(posedge clk_i);
      chk("cmp", o7, cmp);
      wb(1'b1, tic_pkg::ADDR_PORT, 32'h8080, q);
      chk("oe6", oe6, 1'b0);
      cap <= 1'b1;
      jv <= 16'hfff0 + 16'($urandom_range(15));
      jmp <= 1'b1;
      @(posedge clk_i);
      jmp <= 1'b0;
      foreach (modes[i])
      begin
         wb(1'b1, tic_pkg::ADDR_MODE, {24'h0, modes[i], 4'h0}, q);
         w = 8'($urandom_range(100, 40));
         pulse(w, t0);
         for (int k = 0; k < (modes[i] == 4'h7 ? 2 : 1); k++)
         begin
            wait_irq(150, got);
            chk("irq", got, 1'b1);
            rd16(tic_pkg::ADDR_LATEST_LOW, v);
            chk("lag", lag_ok(v, (modes[i] == 4'h6 || k == 1) ? t0 + w : t0), 1'b1);
         end
         wait_irq(150, got);
         chk("extra", got, 1'b0);
      end
      wb(1'b1, tic_pkg::ADDR_MODE, 32'h50, q);
      for (int k = 0; k < 3; k++)
      begin
         pulse(8'd30, t0);
         wait_irq(60, got);
         chk("lock", got, k == 0);
         if (k == 1)
            wb(1'b0, tic_pkg::ADDR_LATEST_LOW, 32'h0, q);
      end
      wb(1'b0, tic_pkg::ADDR_LATEST_HIGH, 32'h0, q);
      pulse(8'd1, t0);
      wait_irq(60, got);
      chk("glitch", got, 1'b0);
      pulse(8'd8, t0);
      wait_irq(60, got);
      chk("short", got, 1'b1);
      rd16(tic_pkg::ADDR_LATEST_LOW, v);
      wb(1'b1, tic_pkg::ADDR_EARLIER_LOW, 32'h1, q);
      pulse(8'd20, t0);
      wait_irq(60, got);
      chk("pair1", got, 1'b0);
      pulse(8'd20, t1);
      wait_irq(60, got);
      chk("pair2", got, 1'b1);
      rd16(tic_pkg::ADDR_EARLIER_LOW, v);
      chk("early", lag_ok(v, t0), 1'b1);
      rd16(tic_pkg::ADDR_LATEST_LOW, v);
      chk("late", lag_ok(v, t1), 1'b1);
      pulse(8'd20, t0);
      wait_irq(60, got);
      chk("again", got, 1'b1);
      summarize();
   end
endmodule : testbench
